// ===== core/dcl_top.sv
// converter control logic: axi4-lite register slave, conversion trigger,
// enables for the core and the pin buffer, sleep gating.
// assumes sleep mode inputs come from the power manager on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dcl_top
    import dcl_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    input  wire logic                  sleep_standby,
    input  wire logic                  sleep_powerdown,
    input  wire logic                  clk_per_present,
    input  wire logic                  debug_halt,
    input  wire logic [DCL_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [DCL_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output dcl_core_t                  core_ctl
);
    // ==========================================================
    // write channel capture: address and data held until both seen
    logic                  aw_held_r;
    logic                  w_held_r;
    logic [DCL_ADDR_W-1:0] aw_addr_r;
    logic [31:0]           w_data_r;
    logic                  w_strb0_r;
    logic                  wr_fire;
    logic [DCL_ADDR_W-1:0] wr_addr;
    logic [31:0]           wr_data;
    logic                  wr_strb0;

    // accept each channel once, no new write while a response is pending
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end
        else if (wr_fire)
            aw_held_r <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_r  <= 1'b0;
            w_data_r  <= '0;
            w_strb0_r <= 1'b0;
        end
        else if (wr_fire)
            w_held_r <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r  <= 1'b1;
            w_data_r  <= s_axi_wdata;
            w_strb0_r <= s_axi_wstrb[0];
        end
    end

    // ready is registered so outputs come straight from flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                             && !s_axi_bvalid && !wr_fire;
            s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                             && !s_axi_bvalid && !wr_fire;
        end
    end

    // a write fires in the same cycle that both halves are held
    assign wr_fire  = aw_held_r && w_held_r;
    assign wr_addr  = aw_addr_r;
    assign wr_data  = w_data_r;
    assign wr_strb0 = w_strb0_r;

    logic wr_hit_ctl;
    logic wr_hit_code;
    logic wr_mapped;
    assign wr_mapped   = (wr_addr == DCL_ADDR_CONTROL)
                         || (wr_addr == DCL_ADDR_CODE);
    assign wr_hit_ctl  = wr_fire && wr_strb0 && (wr_addr == DCL_ADDR_CONTROL);
    assign wr_hit_code = wr_fire && wr_strb0 && (wr_addr == DCL_ADDR_CODE);

    // write response; unmapped addresses answer slverr
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= DCL_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? DCL_RESP_OKAY : DCL_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ==========================================================
    // registers
    logic [7:0] control_r;
    logic [7:0] code_r;

    // reserved bits are masked off so they never store
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            control_r <= DCL_CONTROL_RESET;
        else if (wr_hit_ctl)
            control_r <= wr_data[7:0] & DCL_CONTROL_MASK;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            code_r <= DCL_CODE_RESET;
        else if (wr_hit_code)
            code_r <= wr_data[7:0];
    end

    // ==========================================================
    // read channel: one read at a time, answer one cycle after address
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= DCL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= DCL_RESP_OKAY;
            if (s_axi_araddr == DCL_ADDR_CONTROL)
                s_axi_rdata <= {24'h000000, control_r};
            else if (s_axi_araddr == DCL_ADDR_CODE)
                s_axi_rdata <= {24'h000000, code_r};
            else
            begin
                s_axi_rdata <= '0;
                s_axi_rresp <= DCL_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // ==========================================================
    // sleep gating: debug halt is deliberately not an input to any term
    logic en_bit;
    logic pin_bit;
    logic stby_bit;
    logic sleep_off;
    logic run_ok;
    logic run_prev_r;
    assign en_bit   = control_r[DCL_BIT_ENABLE];
    assign pin_bit  = control_r[DCL_BIT_PINBUF];
    assign stby_bit = control_r[DCL_BIT_STANDBY];
    // standby stops unless kept running with the clock present
    assign sleep_off = sleep_powerdown
                       || (sleep_standby
                           && !(stby_bit && clk_per_present));
    assign run_ok    = en_bit && !sleep_off;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            run_prev_r <= 1'b0;
        else
            run_prev_r <= run_ok;
    end

    // a start pulse on enable rising, data write while on, or wake
    logic start_nxt;
    assign start_nxt = (wr_hit_code && en_bit && !sleep_off)
                       || (run_ok && !run_prev_r);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            core_ctl <= '0;
        else
        begin
            core_ctl.core_enable       <= run_ok;
            core_ctl.pin_buffer_enable <= run_ok && pin_bit;
            core_ctl.internal_route    <= run_ok;
            core_ctl.conversion_start  <= start_nxt;
            core_ctl.code              <= wr_hit_code ? wr_data[7:0]
                                                      : code_r;
        end
    end

    // ==========================================================
    // checks: one clock domain, so clock and reset are given once here
    default clocking dcl_chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // a code write that lands while the converter runs
    sequence s_code_while_on;
        wr_hit_code && en_bit && !sleep_off;
    endsequence
    // the start pulse that must answer it one cycle later
    sequence s_start_pulse;
        core_ctl.conversion_start;
    endsequence

    a_start_on_code: assert property (s_code_while_on |=> s_start_pulse)
        else $error("code write while on gave no start");
    a_no_start_off: assert property (
        (wr_hit_code && !en_bit) |=> !core_ctl.conversion_start)
        else $error("start while disabled");
    a_enable_start: assert property (
        (run_ok && !$past(run_ok)) |=> core_ctl.conversion_start)
        else $error("enable gave no start");
    a_pin_follows: assert property (
        core_ctl.pin_buffer_enable |-> core_ctl.core_enable && $past(pin_bit))
        else $error("pin buffer on without bit");
    a_pin_driven: assert property (
        (run_ok && pin_bit) |=> core_ctl.pin_buffer_enable)
        else $error("pin buffer off with bit set");
    // internal use must not wait for the pin buffer bit
    a_route_core: assert property (
        (en_bit && !pin_bit && !sleep_off) |=> core_ctl.internal_route)
        else $error("internal route off while enabled");
    a_standby_kept: assert property (
        (en_bit && stby_bit && clk_per_present && sleep_standby
         && !sleep_powerdown) |=> core_ctl.core_enable)
        else $error("standby stopped a kept core");
    a_standby_stop: assert property (
        (sleep_standby && !stby_bit) |=> !core_ctl.core_enable
            && !core_ctl.pin_buffer_enable)
        else $error("standby did not stop core");
    a_powerdown_off: assert property (
        sleep_powerdown |=> !core_ctl.core_enable
            && !core_ctl.pin_buffer_enable)
        else $error("power-down left core on");
    a_wake_on: assert property (
        ($fell(sleep_standby) && en_bit && !sleep_powerdown)
        |=> core_ctl.core_enable && (core_ctl.pin_buffer_enable == pin_bit))
        else $error("wake did not restore enables");
    a_reserved_zero: assert property (
        (control_r & ~DCL_CONTROL_MASK) == 8'h00)
        else $error("reserved control bits set");
    a_code_stored: assert property (
        wr_hit_code |=> code_r == $past(wr_data[7:0]))
        else $error("code not stored");
    a_debug_inert: assert property (
        ($rose(debug_halt) && $stable(control_r) && !sleep_standby
         && !sleep_powerdown && !$past(sleep_standby)
         && !$past(sleep_powerdown))
        |=> core_ctl.core_enable == $past(core_ctl.core_enable))
        else $error("debug halt changed output");
endmodule : dcl_top
`default_nettype wire

// ===== core/dcl_pkg.sv
// package for the converter control block: register map, field layout,
// reset values, bus response codes and the analog core control struct.
// assumes a single peripheral clock domain and an axi4-lite register bus.
package dcl_pkg;
    // ==========================================================
    // register map (printed offsets are not multiples of four,
    // so they are indices and the byte address is index times four)
    localparam logic [7:0] DCL_IDX_CONTROL = 8'h00;
    localparam logic [7:0] DCL_IDX_CODE    = 8'h01;
    localparam int         DCL_ADDR_W      = 4;
    localparam logic [3:0] DCL_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] DCL_ADDR_CODE    = 4'h4;
    // ==========================================================
    // control field positions
    localparam int DCL_BIT_ENABLE  = 0;
    localparam int DCL_BIT_PINBUF  = 6;
    localparam int DCL_BIT_STANDBY = 7;
    localparam logic [7:0] DCL_CONTROL_MASK  = 8'hc1;
    localparam logic [7:0] DCL_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DCL_CODE_RESET    = 8'h00;
    // ==========================================================
    // axi response codes
    localparam logic [1:0] DCL_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DCL_RESP_SLVERR = 2'h2;
    // ==========================================================
    // analog core controls grouped together
    typedef struct packed {
        logic       core_enable;
        logic       pin_buffer_enable;
        logic       internal_route;
        logic       conversion_start;
        logic [7:0] code;
    } dcl_core_t;
endpackage : dcl_pkg

// ===== test/dcl_tb.sv
// bench for the converter control block: register access over axi4-lite,
// conversion trigger, core and pin buffer enables, sleep gating.
// assumes dcl_pkg and dcl_top are compiled first; drives every input itself.
`timescale 1ns/1ps
`default_nettype none
module tb
    import dcl_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic                  core_clk = 1'b0;
    logic                  rst_n    = 1'b0;
    logic                  stby     = 1'b0;
    logic                  pdn      = 1'b0;
    logic                  clkp     = 1'b1;
    logic                  dbg      = 1'b0;
    logic [DCL_ADDR_W-1:0] awaddr   = 4'h0;
    logic [DCL_ADDR_W-1:0] araddr   = 4'h0;
    logic [31:0]           wdata    = 32'h0;
    logic                  awvalid  = 1'b0;
    logic                  wvalid   = 1'b0;
    logic                  bready   = 1'b0;
    logic                  arvalid  = 1'b0;
    logic                  rready   = 1'b0;
    logic                  awready, wready, bvalid, arready, rvalid;
    logic [1:0]            bresp, rresp;
    logic [31:0]           rdata;
    dcl_core_t             core_ctl;
    // bench model state, kept in step with every write and sleep change
    int                    n_mismatch = 0;
    int                    n_checks   = 0;
    int                    n_start    = 0;
    int                    m_starts   = 0;
    logic [7:0]            m_ctl      = 8'h00;
    logic [7:0]            m_code     = 8'h00;
    logic                  m_run      = 1'b0;
    logic                  m_sb       = 1'b0;
    logic                  m_pd       = 1'b0;
    logic                  m_cp       = 1'b1;
    logic [31:0]           seed       = 32'h0000002d;
    logic [31:0]           v;

    always #20 core_clk = ~core_clk;

    dcl_top DUT (
        .core_clk(core_clk), .rst_n(rst_n), .sleep_standby(stby),
        .sleep_powerdown(pdn), .clk_per_present(clkp), .debug_halt(dbg),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_ctl(core_ctl)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // power-down stops the core; standby does unless run-in-standby holds with the clock there
    function automatic logic off();
        return m_pd | (m_sb & !(m_ctl[DCL_BIT_STANDBY] & m_cp));
    endfunction : off

    // a rise of the run state restarts conversion, wake included
    task automatic upd_run();
        logic r;
        r = m_ctl[DCL_BIT_ENABLE] & !off();
        if (r && !m_run)
            m_starts++;
        m_run = r;
    endtask : upd_run

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // both channels offered together; each released at its own handshake
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        logic ok;
        ok = (a == DCL_ADDR_CONTROL) || (a == DCL_ADDR_CODE);
        // model moves first: a code write's start pulse shows on the same edge as the response, an enabling control write's one edge later
        if (a == DCL_ADDR_CODE)
        begin
            m_code = d;
            if (m_run)
                m_starts++;
        end
        if (a == DCL_ADDR_CONTROL)
        begin
            m_ctl = d & DCL_CONTROL_MASK;
            upd_run();
        end
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", ok ? DCL_RESP_OKAY : DCL_RESP_SLVERR, bresp);
        // one idle edge so a following call never re-drives bready at once
        @(posedge core_clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a);
        logic [31:0] e;
        logic        ok;
        ok = (a == DCL_ADDR_CONTROL) || (a == DCL_ADDR_CODE);
        e = (a == DCL_ADDR_CONTROL) ? {24'h0, m_ctl} :
            (a == DCL_ADDR_CODE) ? {24'h0, m_code} : 32'h0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", e, rdata);
        chk("rresp", ok ? DCL_RESP_OKAY : DCL_RESP_SLVERR, rresp);
        // one idle edge so a following call never re-drives rready at once
        @(posedge core_clk);
    endtask : reg_rd

    task automatic set_sleep(input logic s, p, c);
        stby <= s;
        pdn <= p;
        clkp <= c;
        m_sb = s;
        m_pd = p;
        m_cp = c;
        upd_run();
    endtask : set_sleep

    // outputs are registered, so give them a few cycles before comparing
    task automatic verify();
        repeat (4) @(posedge core_clk);
        chk("core_enable", m_run, core_ctl.core_enable);
        // the buffer only runs while the core itself runs
        chk("pin_buffer", m_run & m_ctl[DCL_BIT_PINBUF],
            core_ctl.pin_buffer_enable);
        chk("internal_route", m_run, core_ctl.internal_route);
        chk("code", m_code, core_ctl.code);
        chk("starts", m_starts, n_start);
    endtask : verify

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // start pulses seen mid-cycle, clear of the edge that launches them
    always @(negedge core_clk)
        if (core_ctl.conversion_start === 1'b1)
        begin
            n_start++;
            chk("start_code", m_code, core_ctl.code);
        end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        reg_rd(DCL_ADDR_CONTROL);
        reg_rd(DCL_ADDR_CODE);
        reg_rd(4'h8);
        reg_wr(4'hc, 8'h5a);
        reg_rd(DCL_ADDR_CODE);
        // the reference is chosen outside the block, so setup starts with
        // output use (internal only), then the code, then the enable
        reg_wr(DCL_ADDR_CONTROL, 8'h3e);
        reg_rd(DCL_ADDR_CONTROL);
        v = xs();
        reg_wr(DCL_ADDR_CODE, v[7:0]);
        verify();
        reg_wr(DCL_ADDR_CONTROL, 8'h01);
        verify();
        for (int i = 0; i < 4; i++)
        begin
            v = xs();
            reg_wr(DCL_ADDR_CODE, v[7:0]);
        end
        verify();
        reg_rd(DCL_ADDR_CODE);
        reg_wr(DCL_ADDR_CONTROL, 8'h41);
        verify();
        reg_wr(DCL_ADDR_CONTROL, 8'h40);
        verify();
        // standby with clock, standby without, power-down; both settings
        for (int k = 0; k < 6; k++)
        begin
            reg_wr(DCL_ADDR_CONTROL, (k < 3) ? 8'h41 : 8'hc1);
            set_sleep(k % 3 != 2, k % 3 == 2, k % 3 == 0);
            v = xs();
            reg_wr(DCL_ADDR_CODE, v[7:0]);
            verify();
            set_sleep(1'b0, 1'b0, 1'b1);
            verify();
        end
        dbg <= 1'b1;
        v = xs();
        reg_wr(DCL_ADDR_CODE, v[7:0]);
        verify();
        conclude();
    end

    // cuts a hang short well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        conclude();
    end
endmodule : tb
`default_nettype wire
